/* rtl/acqc_pkg.sv */
// Shared constants and types for the acquisition control register block
package acqc_pkg;
    // Register offsets
    localparam logic [4:0] ADDR_GAIN_MUX = 5'h04;
    localparam logic [4:0] ADDR_IO_PIN_STATE = 5'h05;
    localparam logic [4:0] ADDR_IO_DIRECTION_CONTROL = 5'h06;
    localparam logic [4:0] ADDR_REFERENCE_OSCILLATOR_CONFIG = 5'h07;
    // Field positions
    localparam int CONVERT_BUSY_BIT = 7;
    localparam int GAIN_LSB = 4;
    localparam int CHANNEL_LSB = 0;
    localparam int POLARITY_SWAP_POS = 2;
    localparam int DIFF_SELECT_POS = 3;
    localparam int REF_CLOCK_SOURCE_BIT = 5;
    localparam int OSC_POWER_BIT = 4;
    localparam int REF_POWER_BIT = 3;
    localparam int BUFFER_POWER_BIT = 2;
    localparam int TWO_VOLT_BIT = 1;
    localparam int BANDGAP_BIT = 0;
    // Reset values
    localparam logic [2:0] GAIN_RESET = 3'h0;
    localparam logic [3:0] CHANNEL_RESET = 4'h0;
    localparam logic [3:0] DIRECTION_RESET = 4'h0;
    localparam logic [3:0] PIN_LATCH_RESET = 4'h0;
    localparam logic [5:0] REF_OSC_RESET = 6'h00;
    // Timing
    localparam int SYS_FREQ_KHZ = 10000;
    localparam int OSC_FREQ_KHZ = 2500;
    localparam int OSC_HALF_CYCLES = SYS_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
    localparam logic [1:0] START_FALL_COUNT = 2'h2;
    // Conversion sequencer
    typedef enum logic [1:0] {
        ACQC_IDLE = 2'b00,
        ACQC_ARMED = 2'b01,
        ACQC_CONVERTING = 2'b10
    } acqc_conv_state_t;
    // Reference voltage choice
    typedef enum logic [1:0] {
        ACQC_VREF_2V5 = 2'b00,
        ACQC_VREF_2V048 = 2'b01,
        ACQC_VREF_1V15 = 2'b10
    } acqc_vref_t;
endpackage

/* rtl/acqc_clock_divider.sv */
// Conversion clock divider producing the divided clock and its falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module acqc_clock_divider #(
    parameter int COUNT_W = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic srcLevel,
    input wire logic [1:0] divideSelect,
    output logic dividedLevel,
    output logic dividedFall
);
    initial begin
        if (COUNT_W < 3) $error("divider needs three count bits");
    end
    logic srcPrev; // Source level one cycle ago
    logic [COUNT_W-1:0] count; // Counts source falling edges
    logic levelPrev; // Divided level one cycle ago
    // Source edge tracking and count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            srcPrev <= 1'b0;
            count <= '0;
        end else if (ce) begin
            srcPrev <= srcLevel;
            if (srcPrev && !srcLevel) begin
                count <= count + 1'b1;
            end
        end
    end
    // Select divide by 1, 2, 4 or 8
    always_comb begin
        case (divideSelect)
            2'h0: dividedLevel = srcLevel; // R19
            2'h1: dividedLevel = ~count[0];
            2'h2: dividedLevel = ~count[1];
            default: dividedLevel = ~count[2];
        endcase
    end
    // Falling edge of the divided clock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            levelPrev <= 1'b0;
        end else if (ce) begin
            levelPrev <= dividedLevel;
        end
    end
    assign dividedFall = levelPrev & ~dividedLevel;
endmodule // acqc_clock_divider
`default_nettype wire

/* rtl/acqc_pin_filter.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module acqc_pin_filter #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pinAsync,
    output logic [WIDTH-1:0] pinLevel
);
    initial begin
        if (WIDTH < 1) $error("filter width must be at least one");
    end
    logic [WIDTH-1:0] stage1; // Metastable capture, read only by stage2
    logic [WIDTH-1:0] stage2; // Settled copy
    logic [WIDTH-1:0] stage3; // Agreement reference
    // Synchroniser chain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (ce) begin
            stage1 <= pinAsync;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end
    // Accept a bit only once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinLevel <= '0;
        end else if (ce) begin
            pinLevel <= (pinLevel & (stage2 ^ stage3)) | (stage2 & stage3);
        end
    end
endmodule // acqc_pin_filter
`default_nettype wire

/* rtl/acqc_regs.sv */
// Control registers for the acquisition front end: mux, gain, convert, I/O port, reference and oscillator
// Notes on behaviour
// R1: Convert bit write starts on second divided fall
// R2: Convert bit reads one while converting
// R3: Channel bits set switches; bit two swaps polarity
// R4: Gain code picks one of eight gains
// R5: Gains ascend 1,2,4,5,8,10,16,20 by code
// R6: Input pins ignore writes, follow pin
// R7: Output pins drive last written value
// R8: State register reads actual pin levels
// R9: Bits six to four read zero
// R10: Direction one is output; inputs after reset
// R11: Host writes zeros to reserved bits
// R12: Source bit picks oscillator, else divided pin
// R13: Oscillator enable powers oscillator, drives pin
// R14: Source and reference enable run oscillator only
// R15: Oscillator on by pin or either bit
// R16: Enable bits power reference and buffer
// R17: Bandgap gives 1.15 V, else two-volt choice
// R18: Reference and oscillator bits reset to zero
// R19: Divided clock is pin over 1,2,4,8
// R20: Busy holds until done; starts while busy ignored
`timescale 1ns/1ps
`default_nettype none
module acqc_regs #(
    parameter int PIN_COUNT = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    output logic regReadValid,
    input wire logic [1:0] clockDivideSelect,
    input wire logic conversionDone,
    output logic conversionStart,
    output logic convertBusy,
    output logic [2:0] gainSelect,
    output logic [4:0] gainValue,
    output logic [3:0] channelSelect,
    output logic differentialMode,
    output logic polaritySwap,
    input wire logic [PIN_COUNT-1:0] ioPinIn,
    output logic [PIN_COUNT-1:0] ioPinOut,
    output logic [PIN_COUNT-1:0] ioPinOe,
    input wire logic convClockPinIn,
    output logic convClockPinOut,
    output logic convClockPinOe,
    input wire logic pinA,
    output logic oscRunning,
    output logic refClock,
    output logic refPowerOn,
    output logic bufferPowerOn,
    output acqc_pkg::acqc_vref_t refVoltage
);
    initial begin
        if (PIN_COUNT != 4) $error("register layout holds exactly four pins");
    end

    // Stored fields
    logic [2:0] gainReg; // Gain code
    logic [3:0] channelReg; // Channel code
    logic [PIN_COUNT-1:0] pinLatch; // Written output values
    logic [PIN_COUNT-1:0] directionReg; // One marks an output
    logic [5:0] refOscReg; // Source, osc, ref, buffer, two-volt, bandgap
    acqc_pkg::acqc_conv_state_t convState; // Conversion sequencer
    logic [1:0] fallCount; // Divided falls seen while armed
    logic [7:0] oscCount; // Oscillator half-period counter
    logic oscLevel; // Internal oscillator output
    logic [PIN_COUNT-1:0] pinLevel; // Filtered pin levels
    logic convClockLevel; // Filtered conversion clock pin
    logic pinAFiltered; // Filtered oscillator enable pin
    logic dclkLevel; // Divided clock level
    logic dclkFall; // Divided clock falling edge
    logic startRequest; // Convert bit written as one
    logic oscOn; // Oscillator power term
    logic convClockSource; // Clock feeding the divider

    // Decoded write strobes
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
        hit = (addr == target);
    endfunction

    // Gain code to amplifier gain
    function automatic logic [4:0] gain_of(input logic [2:0] code);
        case (code)
            3'h0: gain_of = 5'h01; // R5
            3'h1: gain_of = 5'h02;
            3'h2: gain_of = 5'h04;
            3'h3: gain_of = 5'h05;
            3'h4: gain_of = 5'h08;
            3'h5: gain_of = 5'h0A;
            3'h6: gain_of = 5'h10;
            default: gain_of = 5'h14;
        endcase
    endfunction

    // Synchronise the I/O pins
    acqc_pin_filter #(
        .WIDTH(PIN_COUNT)
    ) u_io_filter (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .pinAsync(ioPinIn),
        .pinLevel(pinLevel)
    );

    // Synchronise the clock pin and the oscillator enable pin
    acqc_pin_filter #(
        .WIDTH(2)
    ) u_misc_filter (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .pinAsync({pinA, convClockPinIn}),
        .pinLevel({pinAFiltered, convClockLevel})
    );

    // Oscillator power combines pin and both control paths
    assign oscOn = pinAFiltered
        | refOscReg[acqc_pkg::OSC_POWER_BIT] // R15
        | (refOscReg[acqc_pkg::REF_CLOCK_SOURCE_BIT] & refOscReg[acqc_pkg::REF_POWER_BIT]); // R14

    // When the oscillator drives the pin it is the conversion clock
    assign convClockSource = refOscReg[acqc_pkg::OSC_POWER_BIT] ? oscLevel : convClockLevel;

    // Divider for the conversion pacing clock
    acqc_clock_divider #(
        .COUNT_W(3)
    ) u_divider (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .srcLevel(convClockSource),
        .divideSelect(clockDivideSelect),
        .dividedLevel(dclkLevel),
        .dividedFall(dclkFall)
    );

    // Convert bit written as one through either register
    assign startRequest = regWrite && regWriteData[acqc_pkg::CONVERT_BUSY_BIT]
        && (hit(regAddr, acqc_pkg::ADDR_GAIN_MUX) || hit(regAddr, acqc_pkg::ADDR_IO_PIN_STATE)); // R1

    // Gain and channel fields
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gainReg <= acqc_pkg::GAIN_RESET;
            channelReg <= acqc_pkg::CHANNEL_RESET;
        end else if (ce && regWrite && hit(regAddr, acqc_pkg::ADDR_GAIN_MUX)) begin
            gainReg <= regWriteData[acqc_pkg::GAIN_LSB +: 3]; // R4
            channelReg <= regWriteData[acqc_pkg::CHANNEL_LSB +: 4]; // R3
        end
    end

    // Output latch: only output pins take written values
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinLatch <= acqc_pkg::PIN_LATCH_RESET;
        end else if (ce && regWrite && hit(regAddr, acqc_pkg::ADDR_IO_PIN_STATE)) begin
            pinLatch <= (pinLatch & ~directionReg) | (regWriteData[PIN_COUNT-1:0] & directionReg); // R6
        end
    end

    // Direction bits; upper bits are dropped, host keeps them zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            directionReg <= acqc_pkg::DIRECTION_RESET; // R10
        end else if (ce && regWrite && hit(regAddr, acqc_pkg::ADDR_IO_DIRECTION_CONTROL)) begin
            directionReg <= regWriteData[PIN_COUNT-1:0]; // R11
        end
    end

    // Reference and oscillator configuration
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            refOscReg <= acqc_pkg::REF_OSC_RESET; // R18
        end else if (ce && regWrite && hit(regAddr, acqc_pkg::ADDR_REFERENCE_OSCILLATOR_CONFIG)) begin
            refOscReg <= regWriteData[5:0]; // R11
        end
    end

    // Pin drivers straight from flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ioPinOut <= '0;
            ioPinOe <= '0;
        end else if (ce) begin
            ioPinOut <= pinLatch; // R7
            ioPinOe <= (regWrite && hit(regAddr, acqc_pkg::ADDR_IO_DIRECTION_CONTROL))
                ? regWriteData[PIN_COUNT-1:0] : directionReg; // R10
        end
    end

    // Internal oscillator; divides the system clock while powered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oscCount <= 8'h00;
            oscLevel <= 1'b0;
        end else if (ce) begin
            if (!oscOn) begin
                oscCount <= 8'h00; // Powered down, parks low
                oscLevel <= 1'b0;
            end else if (oscCount == 8'(acqc_pkg::OSC_HALF_CYCLES - 1)) begin
                oscCount <= 8'h00;
                oscLevel <= ~oscLevel; // R15
            end else begin
                oscCount <= oscCount + 8'h01;
            end
        end
    end

    // Clock pin drive: only the oscillator enable bit turns it round
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            convClockPinOut <= 1'b0;
            convClockPinOe <= 1'b0;
        end else if (ce) begin
            convClockPinOut <= oscLevel & refOscReg[acqc_pkg::OSC_POWER_BIT]; // R13
            convClockPinOe <= refOscReg[acqc_pkg::OSC_POWER_BIT]; // R14
        end
    end

    // Reference clock and power outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            refClock <= 1'b0;
            oscRunning <= 1'b0;
            refPowerOn <= 1'b0;
            bufferPowerOn <= 1'b0;
        end else if (ce) begin
            refClock <= refOscReg[acqc_pkg::REF_CLOCK_SOURCE_BIT] ? oscLevel : dclkLevel; // R12
            oscRunning <= oscOn; // R15
            refPowerOn <= refOscReg[acqc_pkg::REF_POWER_BIT]; // R16
            bufferPowerOn <= refOscReg[acqc_pkg::BUFFER_POWER_BIT]; // R16
        end
    end

    // Reference voltage choice; bandgap overrides two-volt
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            refVoltage <= acqc_pkg::ACQC_VREF_2V5;
        end else if (ce) begin
            if (refOscReg[acqc_pkg::BANDGAP_BIT]) begin
                refVoltage <= acqc_pkg::ACQC_VREF_1V15; // R17
            end else if (refOscReg[acqc_pkg::TWO_VOLT_BIT]) begin
                refVoltage <= acqc_pkg::ACQC_VREF_2V048; // R17
            end else begin
                refVoltage <= acqc_pkg::ACQC_VREF_2V5;
            end
        end
    end

    // Amplifier and switch settings
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gainSelect <= acqc_pkg::GAIN_RESET;
            gainValue <= 5'h01;
            channelSelect <= acqc_pkg::CHANNEL_RESET;
            differentialMode <= 1'b1;
            polaritySwap <= 1'b0;
        end else if (ce) begin
            gainSelect <= gainReg; // R4
            gainValue <= gain_of(gainReg); // R5
            channelSelect <= channelReg; // R3
            // Top channel bit low selects a differential pair
            differentialMode <= ~channelReg[acqc_pkg::DIFF_SELECT_POS]; // R3
            polaritySwap <= ~channelReg[acqc_pkg::DIFF_SELECT_POS]
                & channelReg[acqc_pkg::POLARITY_SWAP_POS]; // R3
        end
    end

    // Conversion sequencer: arm, wait two divided falls, run till done
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            convState <= acqc_pkg::ACQC_IDLE;
            fallCount <= 2'h0;
            conversionStart <= 1'b0;
        end else if (ce) begin
            conversionStart <= 1'b0;
            case (convState)
                acqc_pkg::ACQC_IDLE: begin
                    fallCount <= 2'h0;
                    if (startRequest) begin
                        convState <= acqc_pkg::ACQC_ARMED; // R1
                    end
                end
                acqc_pkg::ACQC_ARMED: begin
                    // Requests here are ignored, a start is already pending
                    if (dclkFall) begin
                        if (fallCount == acqc_pkg::START_FALL_COUNT - 2'h1) begin
                            convState <= acqc_pkg::ACQC_CONVERTING; // R1
                            conversionStart <= 1'b1;
                        end
                        fallCount <= fallCount + 2'h1;
                    end
                end
                acqc_pkg::ACQC_CONVERTING: begin
                    if (conversionDone) begin
                        convState <= acqc_pkg::ACQC_IDLE; // R20
                    end
                end
                default: begin
                    convState <= acqc_pkg::ACQC_IDLE;
                end
            endcase
        end
    end

    // Busy level; a start that is armed already counts as busy
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            convertBusy <= 1'b0;
        end else if (ce) begin
            convertBusy <= convState == acqc_pkg::ACQC_ARMED
                || (convState == acqc_pkg::ACQC_CONVERTING && !conversionDone)
                || (convState == acqc_pkg::ACQC_IDLE && startRequest); // R20
        end
    end

    // Read path; unmapped addresses return zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regReadData <= 8'h00;
            regReadValid <= 1'b0;
        end else if (ce) begin
            regReadValid <= regRead;
            if (regRead) begin
                if (hit(regAddr, acqc_pkg::ADDR_GAIN_MUX)) begin
                    regReadData <= {convertBusy, gainReg, channelReg}; // R2
                end else if (hit(regAddr, acqc_pkg::ADDR_IO_PIN_STATE)) begin
                    regReadData <= {convertBusy, 3'h0, pinLevel}; // R8 R9
                end else if (hit(regAddr, acqc_pkg::ADDR_IO_DIRECTION_CONTROL)) begin
                    regReadData <= {4'h0, directionReg};
                end else if (hit(regAddr, acqc_pkg::ADDR_REFERENCE_OSCILLATOR_CONFIG)) begin
                    regReadData <= {2'h0, refOscReg};
                end else begin
                    regReadData <= 8'h00;
                end
            end
        end
    end
endmodule // acqc_regs
`default_nettype wire

/* verif/acqc_host_model.sv */
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module acqc_host_model (
    input wire logic clk_sys,
    output logic regWrite,
    output logic regRead,
    output logic [4:0] regAddr,
    output logic [7:0] regWriteData
);
    // Idle bus at time zero
    initial begin
        regWrite = 1'h0;
        regRead = 1'h0;
        regAddr = 5'h1F;
        regWriteData = 8'hA5;
    end

    // Reserved bits of the direction and reference registers are cleared before a write leaves the host
    function automatic logic [7:0] clean(input logic [4:0] a, input logic [7:0] d);
        case (a)
            acqc_pkg::ADDR_IO_DIRECTION_CONTROL: clean = d & 8'h0F;
            acqc_pkg::ADDR_REFERENCE_OSCILLATOR_CONFIG: clean = d & 8'h3F;
            default: clean = d;
        endcase
    endfunction

    // One write cycle; lines flip afterwards so stale values never look valid
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'h1;
        regAddr <= a;
        regWriteData <= clean(a, d);
        @(posedge clk_sys);
        regWrite <= 1'h0;
        regAddr <= ~a;
        regWriteData <= ~d;
    endtask

    // One read request cycle
    task automatic rd(input logic [4:0] a);
        @(posedge clk_sys);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'h0;
        regAddr <= ~a;
    endtask
endmodule // acqc_host_model
`default_nettype wire

/* verif/acqc_regs_monitor.sv */
// Port checker for the acquisition control register block
`timescale 1ns/1ps
`default_nettype none
module acqc_regs_monitor #(
    parameter int PIN_COUNT = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regReadValid,
    input wire logic conversionDone,
    input wire logic conversionStart,
    input wire logic convertBusy,
    input wire logic [2:0] gainSelect,
    input wire logic [4:0] gainValue,
    input wire logic [3:0] channelSelect,
    input wire logic differentialMode,
    input wire logic polaritySwap,
    input wire logic [PIN_COUNT-1:0] ioPinOe,
    input wire logic convClockPinOe,
    input var acqc_pkg::acqc_vref_t refVoltage
);
    // Gain per code, ascending
    localparam logic [4:0] GAIN_TABLE [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h10, 5'h14};
    default clocking monCb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Accepted convert request from either register while idle
    sequence convWrite;
        ce && regWrite && regWriteData[7] && !convertBusy
            && (regAddr == acqc_pkg::ADDR_GAIN_MUX || regAddr == acqc_pkg::ADDR_IO_PIN_STATE);
    endsequence
    // Two divided falls cannot pass in under four cycles
    sequence startWait;
        (!conversionStart)[*4] ##[1:300] conversionStart;
    endsequence
    // Write to the reference register
    sequence refWrite;
        ce && regWrite && regAddr == acqc_pkg::ADDR_REFERENCE_OSCILLATOR_CONFIG;
    endsequence

    AST_START_WINDOW: assert property (convWrite |=> startWait) else $error("start late");
    AST_BUSY_SET: assert property (convWrite |=> convertBusy) else $error("busy not set");
    AST_DONE_CLEARS: assert property (conversionDone && convertBusy && !conversionStart |=> !convertBusy)
        else $error("busy stuck");
    AST_GAIN_MAP: assert property (gainValue == GAIN_TABLE[gainSelect]) else $error("gain map");
    AST_DIFF_MODE: assert property (differentialMode == !channelSelect[3]) else $error("diff flag");
    AST_POLARITY: assert property (polaritySwap == (!channelSelect[3] && channelSelect[2]))
        else $error("polarity");
    AST_PIN_DIR: assert property (ce && regWrite && regAddr == acqc_pkg::ADDR_IO_DIRECTION_CONTROL
        |=> ioPinOe == $past(regWriteData[PIN_COUNT-1:0]))
        else $error("pin enable");
    AST_OSC_PIN: assert property (refWrite ##0 regWriteData[4] |-> ##[1:2] convClockPinOe)
        else $error("clock pin");
    AST_BANDGAP: assert property (refWrite ##0 regWriteData[0] |-> ##[1:2] refVoltage == acqc_pkg::ACQC_VREF_1V15)
        else $error("bandgap");
    AST_READ_VALID: assert property (ce && regRead |=> regReadValid) else $error("read valid");
endmodule // acqc_regs_monitor
bind acqc_regs acqc_regs_monitor #(.PIN_COUNT(PIN_COUNT)) acqc_regs_monitor_i (.*);
`default_nettype wire

/* verif/acqc_regs_test.sv */
// Self-checking bench for the acquisition control register block
`timescale 1ns/1ps
`default_nettype none
module acqc_regs_test;
    localparam logic [4:0] GAIN_TABLE [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h10, 5'h14};
    logic clk_sys, rst, regWrite, regRead, regReadValid, conversionDone, conversionStart, convertBusy;
    logic differentialMode, polaritySwap, convClockPinOut, convClockPinOe, pinA, oscRunning, refClock;
    logic refPowerOn, bufferPowerOn, extClk;
    logic [4:0] regAddr, gainValue;
    logic [7:0] regWriteData, regReadData, v;
    logic [1:0] clockDivideSelect;
    logic [2:0] gainSelect;
    logic [3:0] channelSelect, ioPinOut, ioPinOe, ioExt, ch, dir, val;
    logic [5:0] r;
    acqc_pkg::acqc_vref_t refVoltage;
    logic [7:0] expQ [$]; // Expected read data, oldest first
    int miscompares, samplesChecked, startCount, n, t, p;
    // Pin wires resolved from both drivers
    wire logic [3:0] ioPinIn = (ioPinOe & ioPinOut) | (~ioPinOe & ioExt);
    wire logic convClockPinIn = convClockPinOe ? convClockPinOut : extClk;

    acqc_regs #(.PIN_COUNT(4)) acqc_regs_i (.ce(1'h1), .*);
    acqc_host_model acqc_host_model_i (.*);

    // System clock, 100 ns
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    // External conversion clock, 800 ns
    initial begin
        extClk = 1'h0;
        forever begin
            repeat (4) @(posedge clk_sys);
            extClk <= ~extClk;
        end
    end
    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
        samplesChecked++;
        if (seen !== expected) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, expected, seen);
        end
    endtask
    // Read results matched against the oldest note
    always @(posedge clk_sys) begin
        if (regReadValid === 1'h1) begin
            check("regReadData", regReadData, expQ.pop_front());
        end
        if (conversionStart === 1'h1) begin
            startCount++;
        end
    end
    task automatic rdx(input logic [4:0] a, input logic [7:0] e);
        expQ.push_back(e);
        acqc_host_model_i.rd(a);
    endtask
    task automatic settle(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        end_of_test();
    end

    initial begin
        void'($urandom(32));
        rst = 1'h1;
        ioExt = 4'h0;
        pinA = 1'h0;
        conversionDone = 1'h0;
        clockDivideSelect = 2'h0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        settle(1);
        // Power-up state
        check("resetOut", {convertBusy, convClockPinOe, refPowerOn, bufferPowerOn, ioPinOe}, 8'h00);
        check("resetVref", {gainValue, 1'h0, refVoltage}, 8'h08);
        rdx(acqc_pkg::ADDR_IO_DIRECTION_CONTROL, 8'h00);
        rdx(acqc_pkg::ADDR_REFERENCE_OSCILLATOR_CONFIG, 8'h00);
        acqc_host_model_i.wr(5'h1F, 8'hFF);
        rdx(5'h1F, 8'h00);
        // Every gain code with random channel
        for (int g = 0; g < 8; g++) begin
            ch = 4'($urandom);
            acqc_host_model_i.wr(acqc_pkg::ADDR_GAIN_MUX, {1'h0, 3'(g), ch});
            settle(3);
            check("gainValue", {3'h0, gainValue}, {3'h0, GAIN_TABLE[g]});
            check("channel", {2'h0, differentialMode, polaritySwap, channelSelect},
                {2'h0, !ch[3], !ch[3] && ch[2], ch});
            rdx(acqc_pkg::ADDR_GAIN_MUX, {1'h0, 3'(g), ch});
        end
        // Mixed directions; unused state bits written as ones
        for (int k = 0; k < 4; k++) begin
            dir = 4'($urandom);
            val = 4'($urandom);
            acqc_host_model_i.wr(acqc_pkg::ADDR_IO_DIRECTION_CONTROL, {4'hF, dir});
            acqc_host_model_i.wr(acqc_pkg::ADDR_IO_PIN_STATE, {4'h7, val});
            @(posedge clk_sys);
            ioExt <= 4'($urandom);
            settle(8);
            check("pinDrive", {ioPinOe, ioPinOut & dir}, {dir, val & dir});
            rdx(acqc_pkg::ADDR_IO_PIN_STATE, {4'h0, (dir & val) | (~dir & ioExt)});
        end
        // All reference and oscillator settings, random enable pin
        for (int i = 0; i < 64; i++) begin
            r = 6'(i);
            @(posedge clk_sys);
            pinA <= 1'($urandom);
            acqc_host_model_i.wr(acqc_pkg::ADDR_REFERENCE_OSCILLATOR_CONFIG, {2'h3, r});
            settle(6);
            check("refOut", {oscRunning, convClockPinOe, refPowerOn, bufferPowerOn, 2'h0, refVoltage},
                {pinA | r[4] | (r[5] & r[3]), r[4], r[3], r[2], 2'h0, r[0] ? 2'h2 : {1'h0, r[1]}});
            rdx(acqc_pkg::ADDR_REFERENCE_OSCILLATOR_CONFIG, {2'h0, r});
        end
        acqc_host_model_i.wr(acqc_pkg::ADDR_REFERENCE_OSCILLATOR_CONFIG, 8'h00);
        acqc_host_model_i.wr(acqc_pkg::ADDR_IO_DIRECTION_CONTROL, 8'h00);
        @(posedge clk_sys);
        pinA <= 1'h0;
        // Conversions at every divider code, from both registers
        for (int d = 0; d < 4; d++) begin
            @(posedge clk_sys);
            clockDivideSelect <= 2'(d);
            settle(20);
            n = startCount;
            p = 8 << d;
            v = d[0] ? 8'h80 : {1'h1, 7'($urandom)};
            acqc_host_model_i.wr(d[0] ? acqc_pkg::ADDR_IO_PIN_STATE : acqc_pkg::ADDR_GAIN_MUX, v);
            t = 0;
            while (startCount == n && t < 400) begin
                @(posedge clk_sys);
                t++;
            end
            check("startDelay", {7'h0, t >= p && t <= 2 * p + 12}, 8'h01);
            rdx(d[0] ? acqc_pkg::ADDR_IO_PIN_STATE : acqc_pkg::ADDR_GAIN_MUX, d[0] ? {4'h8, ioExt} : v);
            acqc_host_model_i.wr(acqc_pkg::ADDR_GAIN_MUX, 8'h80);
            settle(150);
            check("startCount", 8'(startCount - n), 8'h01);
            @(posedge clk_sys);
            conversionDone <= 1'h1;
            @(posedge clk_sys);
            conversionDone <= 1'h0;
            settle(2);
            check("busyDone", {7'h0, convertBusy}, 8'h00);
            rdx(acqc_pkg::ADDR_IO_PIN_STATE, {4'h0, ioExt});
        end
        settle(4);
        end_of_test();
    end
endmodule // acqc_regs_test
`default_nettype wire
